// >>> rtl/dba_core.sv
// dba_core: four-bank double rate burst memory core with mode registers,
// auto precharge, byte masking, power states and an AHB-Lite register port.
// assumes: i_clock is the true phase of diff_system_clock; all inputs are
// synchronous to it; each clock carries a rise beat and a fall beat.
// Summary of operation
// - commands, addresses and controls are sampled on the rising clock edge only
// - read data leaves as two words per clock, rise beat then fall beat
// - burst counter moves two columns per clock, one per half period
// - a burst starts at the given column and runs the programmed length and order
// - burst length two, four or eight, same for reads and writes
// - sequential or interleaved burst order chosen by a mode bit
// - read latency two, two and a half or three clocks
// - auto precharge closes the row by itself when the burst ends
// - four independent banks of sixteen-bit words, each with its own open row
// - byte masks travel with their write data and block that byte
// - mode and extended mode registers written by the controller
// - extended mode register enables or disables the delay-locked loop
// - precharge power-down with banks idle, active power-down with a row open
// - clock enable low freezes bank and burst state, read outputs and burst address
// - clock enable low with all banks idle enters power-down or self refresh
// - two bank select bits pick the bank of each bank command
// - thirteen-bit row, nine-bit column, address bit ten asks for auto precharge
`timescale 1ns/1ps

module dba_core #(
  parameter int STORE_ROW_BITS = 2,
  parameter int STORE_COL_BITS = 5
) (
  input  wire logic                 i_clock,     // true clock phase
  input  wire logic                 i_resetn,    // async reset, active low
  input  wire logic                 i_cke,       // clock enable
  input  wire dba_pkg::dba_cmd_bus_t i_cmd,      // command, bank, address
  input  wire dba_pkg::dba_wr_t     i_wr,        // write beats and masks
  output dba_pkg::dba_rd_t          o_rd,        // read beats
  output dba_pkg::dba_pwr_t         o_power,     // power state
  output logic                      o_dll_enable, // delay-locked loop on
  input  wire logic                 i_hsel,      // ahb select
  input  wire logic [31:0]          i_haddr,     // ahb address
  input  wire logic [1:0]           i_htrans,    // ahb transfer type
  input  wire logic                 i_hwrite,    // ahb write
  input  wire logic [2:0]           i_hsize,     // ahb size
  input  wire logic [31:0]          i_hwdata,    // ahb write data
  input  wire logic                 i_hready,    // ahb bus ready
  output logic [31:0]               o_hrdata,    // ahb read data
  output logic                      o_hreadyout, // ahb slave ready
  output logic                      o_hresp      // ahb response
);

  localparam int IDX_W = 2 + STORE_ROW_BITS + STORE_COL_BITS;
  localparam int WORDS = 1 << IDX_W;
  localparam int RB    = dba_pkg::ROW_BITS;
  localparam int CB    = dba_pkg::COL_BITS;

  // ==========================================================
  // functions
  function automatic logic [3:0] burst_words(input logic [2:0] code);
    case (code)
      dba_pkg::BL_2: burst_words = 4'h2;
      dba_pkg::BL_4: burst_words = 4'h4;
      default:       burst_words = 4'h8;
    endcase
  endfunction

  // wraps inside the aligned block of the burst length
  function automatic logic [CB-1:0] burst_col(input logic [CB-1:0] base,
                                             input logic [2:0]    k,
                                             input logic [3:0]    len,
                                             input logic          ilv);
    logic [2:0] wrap;
    logic [2:0] off;
    wrap = len[2:0] - 3'h1;
    off  = ilv ? (base[2:0] ^ k) : (base[2:0] + k);
    burst_col = {base[CB-1:3], (base[2:0] & ~wrap) | (off & wrap)};
  endfunction

  function automatic logic [IDX_W-1:0] mem_index(input logic [1:0]    bank,
                                                 input logic [RB-1:0] row,
                                                 input logic [CB-1:0] col);
    mem_index = {bank, row[STORE_ROW_BITS-1:0], col[STORE_COL_BITS-1:0]};
  endfunction

  // ==========================================================
  // state
  localparam int DQ_BITS_W = dba_pkg::DQ_BITS;
  logic [DQ_BITS_W-1:0]  mem [WORDS];
  logic [RB-1:0]         mode_reg;
  logic [RB-1:0]         ext_reg;
  logic [3:0]            bank_open;
  logic [RB-1:0]         open_row [4];
  logic                  burst_active;
  logic                  burst_write;
  logic                  burst_ap;
  logic [1:0]            burst_bank;
  logic [CB-1:0]         burst_base;
  logic [3:0]            burst_len;
  logic                  burst_ilv;
  logic [3:0]            burst_cnt;
  dba_pkg::dba_rd_t      pipe0;
  dba_pkg::dba_rd_t      pipe1;
  dba_pkg::dba_pwr_t     power;
  dba_pkg::dba_pwr_t     next_power;
  logic [15:0]           refresh_count;
  logic                  ahb_wr_pend;
  logic [7:0]            ahb_wr_addr;

  // ==========================================================
  // command decode
  wire [1:0]  cmd_bank  = {i_cmd.bank_select_bit1, i_cmd.bank_select_bit0};
  wire        is_act    = i_cmd.cmd == dba_pkg::row_open_cmd;
  wire        is_rd     = i_cmd.cmd == dba_pkg::read_cmd;
  wire        is_wr     = i_cmd.cmd == dba_pkg::write_cmd;
  wire        is_pre    = i_cmd.cmd == dba_pkg::precharge_cmd;
  wire        is_ref    = i_cmd.cmd == dba_pkg::refresh_cmd;
  wire        is_mrs    = i_cmd.cmd == dba_pkg::mode_write_cmd;
  wire        is_extended_setting_write_cmd   = i_cmd.cmd == dba_pkg::extended_setting_write_cmd;
  wire        pre_all   = i_cmd.addr[dba_pkg::AP_BIT];
  // access to a closed bank is dropped; the row must be opened first
  wire        start     = i_cke && (is_rd || is_wr) && bank_open[cmd_bank];
  wire [2:0]  cl_code   = mode_reg[dba_pkg::MODE_CL_LSB +: 3];
  wire [3:0]  cfg_len   = burst_words(mode_reg[dba_pkg::MODE_BL_LSB +: 3]);
  wire        cfg_ilv   = mode_reg[dba_pkg::MODE_ORDER_BIT];
  wire        step      = i_cke && burst_active;
  wire [3:0]  cnt_next  = burst_cnt + 4'h2;
  wire        burst_last = cnt_next >= burst_len;
  wire [3:0]  cnt_odd   = burst_cnt + 4'h1;
  wire [CB-1:0] col0    = burst_col(burst_base, burst_cnt[2:0], burst_len, burst_ilv);
  wire [CB-1:0] col1    = burst_col(burst_base, cnt_odd[2:0], burst_len, burst_ilv);
  wire [IDX_W-1:0] idx0 = mem_index(burst_bank, open_row[burst_bank], col0);
  wire [IDX_W-1:0] idx1 = mem_index(burst_bank, open_row[burst_bank], col1);
  wire [7:0]  old_lo    = mem[idx0][7:0];
  wire        all_idle  = bank_open == 4'h0;

  // ==========================================================
  // burst engine: two columns per clock
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      burst_active <= 1'b0;
      burst_write  <= 1'b0;
      burst_ap     <= 1'b0;
      burst_bank   <= 2'h0;
      burst_base   <= '0;
      burst_len    <= 4'h2;
      burst_ilv    <= 1'b0;
      burst_cnt    <= 4'h0;
    end
    else if (start)
    begin
      burst_active <= 1'b1;
      burst_write  <= is_wr;
      burst_ap     <= i_cmd.addr[dba_pkg::AP_BIT];
      burst_bank   <= cmd_bank;
      burst_base   <= i_cmd.addr[CB-1:0];
      burst_len    <= cfg_len;
      burst_ilv    <= cfg_ilv;
      burst_cnt    <= 4'h0;
    end
    else if (step)
    begin
      burst_cnt    <= cnt_next;
      burst_active <= !burst_last;
    end
  end

  // ==========================================================
  // storage: masked byte lanes keep their old value
  always_ff @(posedge i_clock)
  begin
    if (step && burst_write)
    begin
      for (int b = 0; b < 2; b++)
      begin
        if (!i_wr.write_byte_mask_rise[b])
          mem[idx0][b*8 +: 8] <= i_wr.data_rise[b*8 +: 8];
        if (!i_wr.write_byte_mask_fall[b])
          mem[idx1][b*8 +: 8] <= i_wr.data_fall[b*8 +: 8];
      end
    end
  end

  // ==========================================================
  // read pipeline and latency select
  wire rd_step = step && !burst_write;
  dba_pkg::dba_rd_t next_rd;
  always_comb
  begin
    case (cl_code)
      dba_pkg::CL_3:   next_rd = pipe1;
      dba_pkg::CL_2P5: next_rd = {pipe1.fall_valid, pipe1.data_fall,
                                  pipe0.rise_valid, pipe0.data_rise};
      default:         next_rd = pipe0;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pipe0 <= '0;
      pipe1 <= '0;
      o_rd  <= '0;
    end
    else if (i_cke)
    begin
      pipe0 <= {rd_step, mem[idx0], rd_step, mem[idx1]};
      pipe1 <= pipe0;
      o_rd  <= next_rd;
    end
  end

  // ==========================================================
  // banks: one open row each
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      bank_open <= 4'h0;
      for (int g = 0; g < 4; g++)
        open_row[g] <= '0;
    end
    else if (i_cke)
    begin
      for (int g = 0; g < 4; g++)
      begin
        if (is_act && cmd_bank == g[1:0])
        begin
          bank_open[g] <= 1'b1;
          open_row[g]  <= i_cmd.addr;
        end
        else if (is_pre && (pre_all || cmd_bank == g[1:0]))
          bank_open[g] <= 1'b0;
        else if (burst_active && burst_last && burst_ap && burst_bank == g[1:0])
          bank_open[g] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // power state; watches i_cke so it is never frozen itself
  always_comb
  begin
    next_power = power;
    case (power)
      dba_pkg::pwr_run:
        if (!i_cke && !burst_active)
        begin
          if (!all_idle)
            next_power = dba_pkg::pwr_active_pd;
          else if (is_ref)
            next_power = dba_pkg::pwr_self_refresh;
          else
            next_power = dba_pkg::pwr_precharge_pd;
        end
      default:
        if (i_cke)
          next_power = dba_pkg::pwr_run;
    endcase
  end

  wire ref_taken = is_ref && (i_cke || next_power == dba_pkg::pwr_self_refresh);

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      power         <= dba_pkg::pwr_run;
      refresh_count <= 16'h0000;
    end
    else
    begin
      power <= next_power;
      if (ref_taken)
        refresh_count <= refresh_count + 16'h0001;
    end
  end

  assign o_power      = power;
  assign o_dll_enable = !ext_reg[dba_pkg::EXT_DLL_DIS];

  // ==========================================================
  // ahb-lite slave, zero wait states
  wire ahb_take = i_hsel && i_htrans[1] && i_hready;
  wire [31:0] status_word = {24'h000000, burst_active, power, 1'b0, bank_open};
  logic [31:0] rd_word;
  always_comb
  begin
    case (i_haddr[7:0])
      dba_pkg::REG_MODE:   rd_word = {19'h00000, mode_reg};
      dba_pkg::REG_EXT:    rd_word = {19'h00000, ext_reg};
      dba_pkg::REG_STATUS: rd_word = status_word;
      dba_pkg::REG_REFCNT: rd_word = {16'h0000, refresh_count};
      default:             rd_word = 32'h00000000;
    endcase
  end

  wire ahb_mode_wr = ahb_wr_pend && ahb_wr_addr == dba_pkg::REG_MODE;
  wire ahb_ext_wr  = ahb_wr_pend && ahb_wr_addr == dba_pkg::REG_EXT;

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ahb_wr_pend <= 1'b0;
      ahb_wr_addr <= 8'h00;
      o_hrdata    <= 32'h00000000;
    end
    else
    begin
      ahb_wr_pend <= ahb_take && i_hwrite;
      ahb_wr_addr <= i_haddr[7:0];
      if (ahb_take && !i_hwrite)
        o_hrdata <= rd_word;
    end
  end

  // a command write in the same cycle beats a bus write
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      mode_reg <= dba_pkg::MODE_RESET;
      ext_reg  <= dba_pkg::EXT_RESET;
    end
    else
    begin
      if (i_cke && is_mrs)
        mode_reg <= i_cmd.addr;
      else if (ahb_mode_wr)
        mode_reg <= i_hwdata[RB-1:0];
      if (i_cke && is_extended_setting_write_cmd)
        ext_reg <= i_cmd.addr;
      else if (ahb_ext_wr)
        ext_reg <= i_hwdata[RB-1:0];
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // ==========================================================
  // assertions
  cke_freeze_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !$past(i_cke) |-> (burst_cnt == $past(burst_cnt) && o_rd == $past(o_rd)))
    else $error("state moved while clock enable was low");

  row_open_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_cke && is_act) |=> (bank_open[$past(cmd_bank)]
                           && open_row[$past(cmd_bank)] == $past(i_cmd.addr)))
    else $error("row open did not take effect");

  lat_two_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (start && is_rd && cl_code == dba_pkg::CL_2 && !burst_active)
      ##1 i_cke [*2] |=> o_rd.rise_valid)
    else $error("latency two first beat missing");

  lat_three_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (start && is_rd && cl_code == dba_pkg::CL_3 && !burst_active)
      ##1 i_cke [*3] |-> !o_rd.rise_valid ##1 o_rd.rise_valid)
    else $error("latency three first beat misplaced");

  lat_half_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (start && is_rd && cl_code == dba_pkg::CL_2P5 && !burst_active)
      ##1 i_cke [*2] |=> (o_rd.fall_valid && !o_rd.rise_valid))
    else $error("half cycle latency first beat misplaced");

  burst_runs_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (start && cfg_len == 4'h8) ##1 (i_cke && !start) [*3] |-> burst_active)
    else $error("burst of eight ended early");

  burst_ends_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (start && cfg_len == 4'h8) ##1 (i_cke && !start) [*4] |=> !burst_active)
    else $error("burst of eight ran too long");

  auto_close_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (step && burst_last && burst_ap && !is_act) |=> !bank_open[$past(burst_bank)])
    else $error("auto precharge left row open");

  mask_keep_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (step && burst_write && i_wr.write_byte_mask_rise[0])
      |=> mem[$past(idx0)][7:0] == $past(old_lo))
    else $error("masked byte was written");

  power_down_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (power == dba_pkg::pwr_run && !i_cke && !burst_active && all_idle && !is_ref)
      |=> power == dba_pkg::pwr_precharge_pd)
    else $error("precharge power-down not entered");

  dll_set_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_cke && is_extended_setting_write_cmd) |=> o_dll_enable == !$past(i_cmd.addr[dba_pkg::EXT_DLL_DIS]))
    else $error("dll setting not applied");

endmodule // dba_core

// >>> rtl/dba_pkg.sv
// dba_pkg: constants and types shared by the burst access core.
// assumes: one clock domain, commands already decoded into dba_cmd_t.
package dba_pkg;

  // ==========================================================
  // geometry
  localparam int BANKS    = 4;
  localparam int ROW_BITS = 13;
  localparam int COL_BITS = 9;
  localparam int DQ_BITS  = 16;
  localparam int AP_BIT   = 10;

  // ==========================================================
  // mode register fields
  localparam int MODE_BL_LSB    = 0;
  localparam int MODE_ORDER_BIT = 3;
  localparam int MODE_CL_LSB    = 4;
  localparam int EXT_DLL_DIS    = 0;

  localparam logic [2:0] BL_2   = 3'h1;
  localparam logic [2:0] BL_4   = 3'h2;
  localparam logic [2:0] BL_8   = 3'h3;
  localparam logic [2:0] CL_2   = 3'h2;
  localparam logic [2:0] CL_2P5 = 3'h6;
  localparam logic [2:0] CL_3   = 3'h3;

  localparam logic [ROW_BITS-1:0] MODE_RESET = 13'h0022;
  localparam logic [ROW_BITS-1:0] EXT_RESET  = 13'h0000;

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] REG_MODE   = 8'h00;
  localparam logic [7:0] REG_EXT    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_REFCNT = 8'h0c;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    nop_cmd,
    row_open_cmd,
    read_cmd,
    write_cmd,
    precharge_cmd,
    refresh_cmd,
    mode_write_cmd,
    extended_setting_write_cmd
  } dba_cmd_t;

  typedef enum logic [1:0] {
    pwr_run,
    pwr_precharge_pd,
    pwr_active_pd,
    pwr_self_refresh
  } dba_pwr_t;

  typedef struct packed {
    dba_cmd_t            cmd;
    logic                bank_select_bit1;
    logic                bank_select_bit0;
    logic [ROW_BITS-1:0] addr;
  } dba_cmd_bus_t;

  typedef struct packed {
    logic [DQ_BITS-1:0] data_rise;
    logic [DQ_BITS-1:0] data_fall;
    logic [1:0]         write_byte_mask_rise;
    logic [1:0]         write_byte_mask_fall;
  } dba_wr_t;

  typedef struct packed {
    logic               rise_valid;
    logic [DQ_BITS-1:0] data_rise;
    logic               fall_valid;
    logic [DQ_BITS-1:0] data_fall;
  } dba_rd_t;

endpackage

// >>> test/dba_core_tb_top.sv
// dba_core_tb_top: self-checking bench for the burst access core.
// assumes: dba_ctrl_model drives the command link, the bench is the ahb master.
`timescale 1ns/1ps

module dba_core_tb_top;
  logic                  clock = 1'b0;
  logic                  resetn = 1'b0;
  dba_pkg::dba_cmd_bus_t cmd;
  dba_pkg::dba_wr_t      wr;
  logic                  cke;
  dba_pkg::dba_rd_t      rd;
  dba_pkg::dba_pwr_t     power;
  logic                  dll_enable;
  logic                  hsel = 1'b0;
  logic [31:0]           haddr = '0;
  logic [1:0]            htrans = 2'b00;
  logic                  hwrite = 1'b0;
  logic [31:0]           hwdata = '0;
  logic [2:0]            hsize = 3'h0;
  logic [31:0]           hrdata;
  logic                  hreadyout;
  logic                  hresp;
  logic                  cke_d = 1'b0;
  logic                  ard = 1'b0;
  integer                errors = 0;
  integer                samples_checked = 0;
  integer                seed = 12977;
  integer                cyc = 0;
  logic [15:0]           mem [int];
  logic [15:0]           eq_d [$];
  integer                eq_t [$];
  logic [31:0]           aq [$];
  logic [2:0]            clc [3] = '{dba_pkg::CL_2, dba_pkg::CL_2P5, dba_pkg::CL_3};
  int                    hh [3] = '{4, 5, 6};

  always #12.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  dba_ctrl_model dba_ctrl_model_i (.i_clock(clock), .o_cmd(cmd), .o_wr(wr), .o_cke(cke));

  dba_core dba_core_i (
    .i_clock(clock), .i_resetn(resetn), .i_cke(cke), .i_cmd(cmd), .i_wr(wr), .o_rd(rd),
    .o_power(power), .o_dll_enable(dll_enable), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp));

  // ==========================================================
  // compare and monitors
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic take(input logic [15:0] d);
    if (eq_d.size() == 0)
      cmp({16'hdead, d}, 32'hffffffff);
    else
      cmp({cyc[15:0], d}, {eq_t.pop_front() & 32'hffff, 16'h0} | eq_d.pop_front());
  endtask

  // frozen cycles hold the last beats; they must not count twice
  always @(posedge clock) cke_d <= cke;
  always @(negedge clock)
    if (resetn && cke_d)
    begin
      if (rd.rise_valid === 1'b1) take(rd.data_rise);
      if (rd.fall_valid === 1'b1) take(rd.data_fall);
    end

  always @(posedge clock)
  begin
    if (ard && aq.size() > 0) cmp(hrdata, aq.pop_front());
    if (ard) cmp({31'h0, hresp}, 32'h0);
    ard <= hsel && htrans[1] && !hwrite && hreadyout;
  end

  // ==========================================================
  // stimulus helpers
  function automatic int key(int b, int r, int c);
    return b * 32'h40000 + r * 512 + c;
  endfunction

  function automatic int bcol(int c, int k, int n, bit ilv);
    return ilv ? (c ^ k) : ((c & ~(n - 1)) | ((c + k) & (n - 1)));
  endfunction

  task automatic ahb(input bit w, input logic [7:0] a, input logic [31:0] wd,
                     input logic [31:0] ex);
    int n;
    n = 0;
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hsize  <= 3'h2;
    hwrite <= w;
    if (!w) aq.push_back(ex);
    do @(posedge clock); while (hreadyout !== 1'b1 && ++n < 50);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1 && ++n < 50);
  endtask

  task automatic wr_burst(int b, int r, int c, int n, bit ilv, bit msk);
    logic [15:0] d [2];
    logic [1:0]  m [2];
    logic [15:0] o;
    int          a;
    dba_ctrl_model_i.go(dba_pkg::write_cmd, 2'(b), {4'h0, 9'(c)}, 1'b1);
    for (int j = 0; j < n; j += 2)
    begin
      for (int h = 0; h < 2; h++)
      begin
        d[h] = 16'($random(seed));
        m[h] = msk ? 2'($random(seed)) : 2'b00;
        a = key(b, r, bcol(c, j + h, n, ilv));
        o = mem.exists(a) ? mem[a] : 16'h0;
        mem[a] = {m[h][1] ? o[15:8] : d[h][15:8], m[h][0] ? o[7:0] : d[h][7:0]};
      end
      dba_ctrl_model_i.beats(d[0], d[1], m[0], m[1]);
    end
  endtask

  task automatic rd_burst(int b, int r, int c, int n, bit ilv, int h, bit ap, int fz, bit ex);
    dba_ctrl_model_i.go(dba_pkg::read_cmd, 2'(b), {2'b00, ap, 1'b0, 9'(c)}, 1'b1);
    for (int k = 0; k < n && ex; k++)
    begin
      eq_d.push_back(mem[key(b, r, bcol(c, k, n, ilv))]);
      eq_t.push_back(cyc + 2 + fz + (h + k) / 2);
    end
    if (fz > 0) dba_ctrl_model_i.freeze(fz);
    dba_ctrl_model_i.idle(n / 2 + 6);
  endtask

  task automatic close_out;
    cmp(eq_d.size(), 0);
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    int bl;
    int il;
    int cl;
    int c;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    ahb(0, dba_pkg::REG_MODE, 0, 32'h22);
    ahb(0, dba_pkg::REG_EXT, 0, 32'h0);
    ahb(1, 8'h10, 32'hffffffff, 0);
    ahb(0, 8'h10, 0, 32'h0);
    ahb(1, dba_pkg::REG_EXT, 32'h1, 0);
    @(negedge clock) cmp(dll_enable, 1'b0);
    dba_ctrl_model_i.go(dba_pkg::extended_setting_write_cmd, 2'b00, 13'h0, 1'b1);
    dba_ctrl_model_i.idle(2);
    cmp(dll_enable, 1'b1);
    for (int b = 0; b < 4; b++)
      dba_ctrl_model_i.go(dba_pkg::row_open_cmd, 2'(b), 13'(b), 1'b1);
    dba_ctrl_model_i.idle(2);
    ahb(0, dba_pkg::REG_STATUS, 0, 32'hf);
    for (int i = 0; i < 18; i++)
    begin
      bl = i % 3;
      il = (i / 3) % 2;
      cl = i / 6;
      c = $random(seed) & 31;
      dba_ctrl_model_i.go(dba_pkg::mode_write_cmd, 2'b00,
                          {6'h0, clc[cl], 1'(il), 3'(bl + 1)}, 1'b1);
      dba_ctrl_model_i.idle(1);
      ahb(0, dba_pkg::REG_MODE, 0, {25'h0, clc[cl], 1'(il), 3'(bl + 1)});
      wr_burst(i % 4, i % 4, c, 2 << bl, il, 0);
      wr_burst(i % 4, i % 4, c, 2 << bl, il, 1);
      rd_burst(i % 4, i % 4, c, 2 << bl, il, hh[cl], 0, (i == 5) ? 2 : 0, 1);
    end
    wr_burst(0, 0, 9, 8, 1, 0);
    rd_burst(0, 0, 9, 8, 1, 6, 1, 0, 1);
    ahb(0, dba_pkg::REG_STATUS, 0, 32'he);
    rd_burst(0, 0, 9, 8, 1, 6, 0, 0, 0);
    dba_ctrl_model_i.go(dba_pkg::precharge_cmd, 2'b00, 13'h0400, 1'b1);
    dba_ctrl_model_i.go(dba_pkg::row_open_cmd, 2'b00, 13'h1, 1'b1);
    wr_burst(0, 1, 20, 8, 1, 0);
    rd_burst(0, 1, 20, 8, 1, 6, 0, 0, 1);
    dba_ctrl_model_i.freeze(3);
    @(negedge clock) cmp(power, dba_pkg::pwr_active_pd);
    dba_ctrl_model_i.go(dba_pkg::precharge_cmd, 2'b00, 13'h0400, 1'b1);
    dba_ctrl_model_i.idle(2);
    cmp(power, dba_pkg::pwr_run);
    ahb(0, dba_pkg::REG_STATUS, 0, 32'h0);
    dba_ctrl_model_i.freeze(3);
    @(negedge clock) cmp(power, dba_pkg::pwr_precharge_pd);
    for (int k = 0; k < 2; k++)
      dba_ctrl_model_i.go(dba_pkg::refresh_cmd, 2'b00, 13'h0, 1'b1);
    dba_ctrl_model_i.idle(2);
    ahb(0, dba_pkg::REG_REFCNT, 0, 32'h2);
    dba_ctrl_model_i.go(dba_pkg::refresh_cmd, 2'b00, 13'h0, 1'b0);
    dba_ctrl_model_i.freeze(2);
    @(negedge clock) cmp(power, dba_pkg::pwr_self_refresh);
    dba_ctrl_model_i.idle(3);
    cmp(power, dba_pkg::pwr_run);
    close_out();
  end

  // run needs under a thousand cycles; twenty thousand means a hang
  initial
  begin
    #(25 * 20000);
    errors++;
    close_out();
  end
endmodule // dba_core_tb_top

// >>> test/dba_ctrl_model.sv
// dba_ctrl_model: controller side of the command link, stepped by the bench.
// assumes: one task at a time, all called from the bench's main process.
`timescale 1ns/1ps

module dba_ctrl_model (
  input  wire logic             i_clock, // true clock phase
  output dba_pkg::dba_cmd_bus_t o_cmd,   // command, bank, address
  output dba_pkg::dba_wr_t      o_wr,    // write beats and masks
  output logic                  o_cke    // clock enable
);
  initial
  begin
    o_cmd = '0;
    o_wr  = '0;
    o_cke = 1'b1;
  end

  // ==========================================================
  // command steps, all launched right after a rising edge
  task automatic go(input dba_pkg::dba_cmd_t c, input logic [1:0] b, input logic [12:0] a,
                    input logic ck);
    @(posedge i_clock);
    o_cmd <= dba_pkg::dba_cmd_bus_t'({c, b, a});
    o_cke <= ck;
    o_wr  <= ~o_wr; // released data lines never repeat a stale beat
  endtask

  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge i_clock);
      o_cmd.cmd <= dba_pkg::nop_cmd;
      o_cke     <= 1'b1;
      o_wr      <= ~o_wr;
    end
  endtask

  task automatic freeze(input int n);
    repeat (n)
    begin
      @(posedge i_clock);
      o_cmd.cmd <= dba_pkg::nop_cmd;
      o_cke     <= 1'b0;
    end
  endtask

  // masks travel in the same cycle as the data they guard
  task automatic beats(input logic [15:0] d0, input logic [15:0] d1,
                       input logic [1:0] m0, input logic [1:0] m1);
    @(posedge i_clock);
    o_cmd.cmd <= dba_pkg::nop_cmd;
    o_cke     <= 1'b1;
    o_wr      <= {d0, d1, m0, m1};
  endtask
endmodule // dba_ctrl_model
